//--- inc/sma_cfg.svh
`ifndef SMA_CFG_SVH
`define SMA_CFG_SVH
`define SMA_DEV_ARRAY 7'h57
`define SMA_DEV_CTRL 7'h6f
`define SMA_ARR_AW 9
`define SMA_CTL_AW 6
`define SMA_STATUS_ADDR 6'h3f
`define SMA_UNLOCK1 8'h02
`define SMA_UNLOCK2 8'h06
`define SMA_MB_SEC 3'h1
`define SMA_RTC_SEC 3'h6
`define SMA_RTC_BYTES 5'h08
`define SMA_MAX_NB 5'h10
`define SMA_ADDR_RST 16'h0000
`define SMA_WR_CYCLE_US 5000
`define SMA_REF_MHZ 50
`define SMA_TMR_W 18
`endif

//--- inc/sma_pkg.sv
`include "sma_cfg.svh"
package sma_pkg;
	typedef logic [7:0] sma_byte_t;
	typedef enum logic [4:0] {
		st_idle = 5'h01,
		st_rx = 5'h02,
		st_ack = 5'h04,
		st_tx = 5'h08,
		st_mack = 5'h10
	} sma_state_t;
	typedef struct packed {
		logic [1:0] scl_s;
		logic [1:0] sda_s;
		logic [1:0] prot_s;
		logic [1:0] done_s;
		logic scl_q;
		logic sda_q;
		sma_state_t st;
		logic [3:0] cnt;
		logic [1:0] bidx;
		logic rd;
		logic cr;
		logic mack;
		sma_byte_t sh;
		logic [15:0] addr;
		logic [15:0] wa;
		logic [4:0] nb;
		sma_byte_t [15:0] pbuf;
		logic [15:0] pval;
		logic lk1;
		logic lk2;
		logic wr_req;
		logic sda_oe;
		logic sda_o;
		sma_byte_t [(1 << `SMA_ARR_AW)-1:0] mem;
		sma_byte_t [(1 << `SMA_CTL_AW)-1:0] ctl;
	} sma_link_t;
	typedef struct packed {
		logic [1:0] req_s;
		logic req_q;
		logic run;
		logic [`SMA_TMR_W-1:0] tmr;
		logic done;
	} sma_ref_t;
endpackage : sma_pkg

//--- hdl/sma_slave.sv
//Operation
//- Acknowledge word address bytes and data byte
//- After valid write stop, self-timed busy cycle
//- Protected write acknowledged but never committed
//- Multi-byte commit registers need multi-byte writes
//- Page limits; timekeeping needs full 8 bytes
//- Address increments, wraps within current page
//- Excess bytes overwrite earlier loaded bytes
//- Stop before full byte plus ack discards
//- Write cycle lasts 5 ms then responsive
//- No acknowledge to polling while busy
//- Counter holds last read plus one
//- Read slave byte: acknowledge, send current byte
//- Stop after word address loads counter
//- Continue reading on ack, stop on nack
//- Sequential read wraps over whole space
//- Acknowledge only matching device address patterns
//- Two word address bytes, high first
`timescale 1ns/1ps
`include "sma_cfg.svh"
module sma_slave
	import sma_pkg::*;
#(
	parameter int unsigned WR_CYCLES = `SMA_WR_CYCLE_US * `SMA_REF_MHZ
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_b,
	input wire logic i_link_clk,
	input wire logic i_scl,
	input wire logic i_sda,
	input wire logic i_upper_half_protect,
	output logic o_sda_o,
	output logic o_sda_oe,
	output logic o_wr_busy
);
	localparam logic [`SMA_TMR_W-1:0] TMR_LOAD = `SMA_TMR_W'(WR_CYCLES - 1);

	sma_link_t q;
	sma_link_t n;
	sma_ref_t r;
	sma_ref_t next_r;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	logic busy;
	logic dev_hit;
	logic wr_end;
	logic wr_ok;
	logic do_load;
	sma_byte_t rdata;
	sma_byte_t v;
	logic [3:0] pi;

	// ****************************************
	// Bus events
	// ****************************************
	// The bus pins are sampled on the link clock, so the clock must run
	// several times faster than the bus clock for edges to be seen.
	assign rise = q.scl_s[1] & ~q.scl_q;
	assign fall = ~q.scl_s[1] & q.scl_q;
	assign start = q.scl_s[1] & q.scl_q & q.sda_q & ~q.sda_s[1];
	assign stop = q.scl_s[1] & q.scl_q & ~q.sda_q & q.sda_s[1];
	assign busy = q.wr_req != q.done_s[1];
	assign dev_hit = (q.sh[7:1] == `SMA_DEV_ARRAY) || (q.sh[7:1] == `SMA_DEV_CTRL);
	// The stop's own clock rise is counted as a bit, so one counted bit at a
	// stop still means that no new byte was begun.
	assign wr_end = (q.st == st_rx) && (q.cnt <= 4'h1) && (q.bidx == 2'h3) &&
		!q.rd && (q.nb != 5'h0);
	assign rdata = q.cr ? q.ctl[q.addr[5:0]] : q.mem[q.addr[8:0]];
	assign pi = q.cr ? {1'b0, q.addr[2:0]} : q.addr[3:0];
	assign v = q.pbuf[{1'b0, q.wa[2:0]}];

	always_comb begin
		if (!q.cr) begin
			wr_ok = !(q.prot_s[1] && q.wa[8]);
		end else begin
			wr_ok = ((q.wa[5:0] == `SMA_STATUS_ADDR) || q.lk2) &&
				!((q.wa[5:3] == `SMA_RTC_SEC) && (q.nb != `SMA_RTC_BYTES)) &&
				!((q.wa[5:3] == `SMA_MB_SEC) && (q.nb < 5'h2));
		end
	end

	// ****************************************
	// Link side engine
	// ****************************************
	always_comb begin
		n = q;
		do_load = 1'b0;
		n.scl_s = {q.scl_s[0], i_scl};
		n.sda_s = {q.sda_s[0], i_sda};
		n.prot_s = {q.prot_s[0], i_upper_half_protect};
		n.done_s = {q.done_s[0], r.done};
		n.scl_q = q.scl_s[1];
		n.sda_q = q.sda_s[1];
		if (start) begin
			// A start during the write cycle clears the transfer state and returns to idle unanswered.
			n.sda_oe = 1'b0;
			n.cnt = 4'h0;
			n.bidx = 2'h0;
			n.nb = 5'h0;
			n.pval = '0;
			n.st = busy ? st_idle : st_rx;
		end else if (stop) begin
			n.sda_oe = 1'b0;
			n.st = st_idle;
			n.pval = '0;
			if (wr_end && wr_ok && !busy) begin
				for (int i = 0; i < 16; i++) begin
					if (q.pval[i]) begin
						if (q.cr) begin
							n.ctl[{q.wa[5:3], 3'(i)}] = q.pbuf[i];
						end else begin
							n.mem[{q.wa[8:4], 4'(i)}] = q.pbuf[i];
						end
					end
				end
				if (q.cr && (q.wa[5:0] == `SMA_STATUS_ADDR)) begin
					n.lk1 = (v == `SMA_UNLOCK1) ||
						((v == `SMA_UNLOCK2) && (q.lk1 || q.lk2));
					n.lk2 = (v == `SMA_UNLOCK2) && (q.lk1 || q.lk2);
				end
				n.wr_req = ~q.wr_req;
			end
		end else if (rise) begin
			unique case (q.st)
				st_rx: begin
					n.sh = {q.sh[6:0], q.sda_s[1]};
					n.cnt = q.cnt + 4'h1;
				end
				st_tx: n.cnt = q.cnt + 4'h1;
				st_mack: n.mack = ~q.sda_s[1];
				st_idle, st_ack: ;
			endcase
		end else if (fall) begin
			unique case (q.st)
				st_rx: begin
					if (q.cnt == 4'h8) begin
						if (q.bidx != 2'h0) begin
							n.sda_oe = 1'b1;
							n.st = st_ack;
						end else if (dev_hit && !busy) begin
							n.sda_oe = 1'b1;
							n.st = st_ack;
							n.rd = q.sh[0];
							n.cr = q.sh[7:1] == `SMA_DEV_CTRL;
						end else begin
							n.st = st_idle;
						end
					end
				end
				st_ack: begin
					n.sda_oe = 1'b0;
					n.cnt = 4'h0;
					n.st = st_rx;
					if (q.rd) begin
						do_load = 1'b1;
					end else begin
						unique case (q.bidx)
							2'h0: n.bidx = 2'h1;
							2'h1: begin
								n.wa[15:8] = q.sh;
								n.bidx = 2'h2;
							end
							2'h2: begin
								n.wa = {q.wa[15:8], q.sh};
								n.addr = {q.wa[15:8], q.sh};
								n.bidx = 2'h3;
							end
							2'h3: begin
								// Excess bytes land on earlier slots of the same page.
								n.pbuf[pi] = q.sh;
								n.pval[pi] = 1'b1;
								if (q.cr) begin
									n.addr = {q.addr[15:3], q.addr[2:0] + 3'h1};
								end else begin
									n.addr = {q.addr[15:4], q.addr[3:0] + 4'h1};
								end
								if (q.nb != `SMA_MAX_NB) begin
									n.nb = q.nb + 5'h1;
								end
							end
						endcase
					end
				end
				st_tx: begin
					if (q.cnt == 4'h8) begin
						n.sda_oe = 1'b0;
						n.st = st_mack;
					end else begin
						n.sda_oe = ~q.sh[7];
						n.sh = {q.sh[6:0], 1'b0};
					end
				end
				st_mack: begin
					if (q.mack) begin
						do_load = 1'b1;
					end else begin
						n.st = st_idle;
					end
				end
				st_idle: ;
			endcase
		end
		if (do_load) begin
			// The counter always points one past the byte being sent.
			n.sh = {rdata[6:0], 1'b0};
			n.sda_oe = ~rdata[7];
			n.cnt = 4'h0;
			n.st = st_tx;
			if (q.cr) begin
				n.addr = {10'h0, q.addr[5:0] + 6'h1};
			end else begin
				n.addr = {7'h0, q.addr[8:0] + 9'h1};
			end
		end
	end

	always_ff @(posedge i_link_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			q <= '0;
			q.st <= st_idle;
			q.addr <= `SMA_ADDR_RST;
		end else begin
			q <= n;
		end
	end

	// ****************************************
	// Write cycle timer
	// ****************************************
	// The request toggle is stable for the whole cycle, so the two
	// stage crossing cannot miss it.
	always_comb begin
		next_r = r;
		next_r.req_s = {r.req_s[0], q.wr_req};
		next_r.req_q = r.req_s[1];
		if (r.req_s[1] != r.req_q) begin
			next_r.run = 1'b1;
			next_r.tmr = TMR_LOAD;
		end else if (r.run) begin
			if (r.tmr == '0) begin
				next_r.run = 1'b0;
				next_r.done = r.req_q;
			end else begin
				next_r.tmr = r.tmr - `SMA_TMR_W'(1);
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign o_sda_o = q.sda_o;
	assign o_sda_oe = q.sda_oe;
	assign o_wr_busy = r.run;

	// ****************************************
	// Checks
	// ****************************************
	property p_dev_nack;
		@(posedge i_link_clk) disable iff (!i_rst_b)
		(fall && q.st == st_rx && q.cnt == 4'h8 && q.bidx == 2'h0 && !dev_hit)
		|=> (q.st == st_idle && !q.sda_oe);
	endproperty
	a_dev_nack: assert property (p_dev_nack) else $error("bad address acknowledged");

	property p_ack_bytes;
		@(posedge i_link_clk) disable iff (!i_rst_b)
		(fall && q.st == st_rx && q.cnt == 4'h8 && q.bidx != 2'h0)
		|=> (q.sda_oe && q.st == st_ack) ##[1:200] (!q.sda_oe);
	endproperty
	a_ack_bytes: assert property (p_ack_bytes) else $error("byte not acknowledged");

	property p_busy_quiet;
		@(posedge i_link_clk) disable iff (!i_rst_b)
		(start && busy) |=> (q.st == st_idle && !q.sda_oe);
	endproperty
	a_busy_quiet: assert property (p_busy_quiet) else $error("answered while busy");

	property p_commit;
		@(posedge i_link_clk) disable iff (!i_rst_b)
		(stop && wr_end && wr_ok && !busy) |=> (q.wr_req != $past(q.wr_req)) && busy;
	endproperty
	a_commit: assert property (p_commit) else $error("write cycle not started");

	property p_protect;
		@(posedge i_link_clk) disable iff (!i_rst_b)
		(stop && wr_end && !wr_ok) |=> $stable(q.wr_req) && $stable(q.mem);
	endproperty
	a_protect: assert property (p_protect) else $error("blocked write committed");

	property p_early_stop;
		@(posedge i_link_clk) disable iff (!i_rst_b)
		(stop && !wr_end) |=> $stable(q.wr_req) && $stable(q.ctl);
	endproperty
	a_early_stop: assert property (p_early_stop) else $error("partial write committed");

	property p_page_wrap;
		@(posedge i_link_clk) disable iff (!i_rst_b)
		(fall && q.st == st_ack && !q.rd && q.bidx == 2'h3 && !q.cr && q.addr[3:0] == 4'hf)
		|=> (q.addr[3:0] == 4'h0 && q.addr[15:4] == $past(q.addr[15:4]));
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("page did not wrap");

	property p_seq_wrap;
		@(posedge i_link_clk) disable iff (!i_rst_b)
		(do_load && !q.cr && q.addr[8:0] == 9'h1ff) |=> (q.addr == 16'h0 && q.st == st_tx);
	endproperty
	a_seq_wrap: assert property (p_seq_wrap) else $error("read counter did not wrap");

	property p_mack_end;
		@(posedge i_link_clk) disable iff (!i_rst_b)
		(fall && q.st == st_mack && !q.mack) |=> (q.st == st_idle && !q.sda_oe);
	endproperty
	a_mack_end: assert property (p_mack_end) else $error("sent after nack");

	property p_set_addr;
		@(posedge i_link_clk) disable iff (!i_rst_b)
		(stop && q.st == st_rx && q.bidx == 2'h3 && q.nb == 5'h0 && q.cnt <= 4'h1)
		|=> (q.st == st_idle && $stable(q.addr) && $stable(q.wr_req));
	endproperty
	a_set_addr: assert property (p_set_addr) else $error("set address misbehaved");

	property p_wr_cycle;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(r.run && r.tmr == '0 && r.req_s[1] == r.req_q) |=> (!r.run && r.done == r.req_q);
	endproperty
	a_wr_cycle: assert property (p_wr_cycle) else $error("write cycle did not end");

	property p_wr_load;
		@(posedge i_ref_clk) disable iff (!i_rst_b)
		(r.req_s[1] != r.req_q) |=> (r.run && r.tmr == TMR_LOAD);
	endproperty
	a_wr_load: assert property (p_wr_load) else $error("write timer not loaded");
endmodule : sma_slave

//--- sim/sma_master.sv
`timescale 1ns/1ps
// ********************************
// Bus master model
// ********************************
// Phases are paced in reference clock falls; each SCL phase spans many link
// clocks so the slave's synchroniser always sees clean levels.
module sma_master (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end
	task automatic half(input int n);
		repeat (n) @(negedge i_clk);
	endtask : half
	task automatic start;
		o_sda_low = 1'b0;
		half(10);
		o_scl = 1'b1;
		half(10);
		o_sda_low = 1'b1;
		half(10);
		o_scl = 1'b0;
		half(5);
	endtask : start
	task automatic stop;
		o_sda_low = 1'b1;
		half(10);
		o_scl = 1'b1;
		half(10);
		o_sda_low = 1'b0;
		half(10);
	endtask : stop
	// Data moves a fifth of a bit after SCL falls, never at the fall itself.
	task automatic bit_x(input logic b, output logic r);
		o_sda_low = !b;
		half(10);
		o_scl = 1'b1;
		half(10);
		r = i_sda;
		o_scl = 1'b0;
		half(5);
	endtask : bit_x
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(d[i], r);
		end
		bit_x(1'b1, r);
		ack = !r;
	endtask : wr_byte
	task automatic rd_byte(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_x(1'b1, r);
			d[i] = r;
		end
		bit_x(!more, r);
	endtask : rd_byte
endmodule : sma_master

//--- sim/sma_slave_test.sv
`timescale 1ns/1ps
// ********************************
// Testbench
// ********************************
module sma_slave_test;
	import sma_pkg::*;
	logic clk;
	logic lclk;
	logic rst_b;
	logic prot;
	logic scl;
	logic m_low;
	logic sda_oe;
	logic sda_o;
	logic busy;
	logic sda;
	int n_fail = 0;
	int compares = 0;
	// The pull-up makes a released line read high.
	assign sda = !(m_low | sda_oe);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		lclk = 1'b0;
		#7;
		forever #15 lclk = ~lclk;
	end
	sma_master u_sma_master (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(m_low));
	sma_slave #(.WR_CYCLES(400)) u_sma_slave (.i_ref_clk(clk), .i_rst_b(rst_b),
		.i_link_clk(lclk), .i_scl(scl), .i_sda(sda), .i_upper_half_protect(prot),
		.o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_wr_busy(busy));
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic send(input logic [7:0] d, input logic exp);
		logic k;
		u_sma_master.wr_byte(d, k);
		chk("ack", k, exp);
	endtask : send
	task automatic set_addr(input logic [15:0] a, input logic [7:0] sb = 8'hae);
		u_sma_master.start();
		send(sb, 1'b1);
		send(a[15:8], 1'b1);
		send(a[7:0], 1'b1);
	endtask : set_addr
	task automatic read_chk(input logic [7:0] q [$], input logic [7:0] sb = 8'haf);
		logic [7:0] d;
		u_sma_master.start();
		send(sb, 1'b1);
		foreach (q[i]) begin
			u_sma_master.rd_byte(i < q.size() - 1, d);
			chk("rd_data", d, q[i]);
		end
		u_sma_master.stop();
	endtask : read_chk
	// Polling uses the array slave byte only; the control slave byte is refused while busy too.
	task automatic commit(input logic exp);
		logic seen;
		logic k;
		int nacks;
		logic quiet;
		seen = 1'b0;
		k = 1'b0;
		nacks = 0;
		quiet = 1'b1;
		repeat (200) begin
			@(negedge clk);
			if (busy === 1'b1) begin
				seen = 1'b1;
				if (sda_oe !== 1'b0) begin
					quiet = 1'b0;
				end
			end
		end
		chk("wr_busy", seen, exp);
		chk("busy_quiet", quiet, 1'b1);
		chk("sda_o", sda_o, 16'h0000);
		while (exp && !k && nacks < 20) begin
			u_sma_master.start();
			u_sma_master.wr_byte(8'hae, k);
			u_sma_master.stop();
			nacks += k ? 0 : 1;
		end
		if (exp) begin
			chk("poll_nack", nacks > 0, 1'b1);
			chk("poll_ack", k, 1'b1);
		end
	endtask : commit
	task automatic t_page;
		set_addr(16'h001e);
		for (int i = 0; i < 18; i++) begin
			send(8'ha0 + i[7:0], 1'b1);
		end
		u_sma_master.stop();
		commit(1'b1);
		set_addr(16'h001e);
		read_chk('{8'hb0, 8'hb1, 8'h00});
		set_addr(16'h0010);
		read_chk('{8'ha2});
		$display("t_page done");
	endtask : t_page
	task automatic t_wrap;
		set_addr(16'h01ff);
		send(8'h5a, 1'b1);
		u_sma_master.stop();
		commit(1'b1);
		set_addr(16'h01ff);
		u_sma_master.stop();
		read_chk('{8'h5a, 8'h00});
		$display("t_wrap done");
	endtask : t_wrap
	task automatic t_protect;
		@(negedge clk);
		prot = 1'b1;
		set_addr(16'h01ff);
		send(8'h33, 1'b1);
		u_sma_master.stop();
		commit(1'b0);
		u_sma_master.start();
		send(8'ha0, 1'b0);
		u_sma_master.stop();
		u_sma_master.start();
		send(8'hde, 1'b1);
		u_sma_master.stop();
		set_addr(16'h01ff);
		read_chk('{8'h5a});
		prot = 1'b0;
		$display("t_protect done");
	endtask : t_protect
	task automatic t_abort;
		logic r;
		set_addr(16'h01ff);
		repeat (4) begin
			u_sma_master.bit_x(1'b0, r);
		end
		u_sma_master.stop();
		commit(1'b0);
		set_addr(16'h01ff);
		read_chk('{8'h5a});
		$display("t_abort done");
	endtask : t_abort
	task automatic t_ctrl;
		set_addr(16'h0000, 8'hde);
		send(8'h11, 1'b1);
		u_sma_master.stop();
		commit(1'b0);
		set_addr(16'h003f, 8'hde);
		send(8'h02, 1'b1);
		u_sma_master.stop();
		commit(1'b1);
		set_addr(16'h003f, 8'hde);
		send(8'h06, 1'b1);
		u_sma_master.stop();
		commit(1'b1);
		set_addr(16'h0008, 8'hde);
		send(8'h55, 1'b1);
		u_sma_master.stop();
		commit(1'b0);
		set_addr(16'h0030, 8'hde);
		send(8'h33, 1'b1);
		u_sma_master.stop();
		commit(1'b0);
		set_addr(16'h0008, 8'hde);
		send(8'h22, 1'b1);
		send(8'h44, 1'b1);
		u_sma_master.stop();
		commit(1'b1);
		set_addr(16'h0000, 8'hde);
		send(8'h11, 1'b1);
		u_sma_master.stop();
		commit(1'b1);
		set_addr(16'h003f, 8'hde);
		read_chk('{8'h06, 8'h11}, 8'hdf);
		set_addr(16'h0008, 8'hde);
		read_chk('{8'h22, 8'h44}, 8'hdf);
		set_addr(16'h0030, 8'hde);
		read_chk('{8'h00}, 8'hdf);
		$display("t_ctrl done");
	endtask : t_ctrl
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : final_report
	initial begin
		repeat (80000) @(posedge clk);
		n_fail++;
		final_report();
	end
	initial begin
		rst_b = 1'b0;
		prot = 1'b0;
		repeat (5) @(negedge clk);
		rst_b = 1'b1;
		repeat (4) @(posedge lclk);
		t_page();
		t_wrap();
		t_protect();
		t_abort();
		t_ctrl();
		final_report();
	end
endmodule : sma_slave_test
